// ==== clock_output_control.sv ====
// Added by the designer: the APB register port.
`default_nettype none

// Output stage control: output seven path and disabled behaviour of outputs 0 to 3.
module clock_output_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        crystal_oscillator,
    input  wire logic        external_clock_input,
    input  wire logic        first_pll,
    input  wire logic        second_pll,
    input  wire logic [3:0]  out_source,
    input  wire logic        output_enable_low_pin,
    output logic [3:0]       out_pin,
    output logic [3:0]       out_pin_oe,
    output logic             output_seven,
    output logic             output_seven_oe,
    output logic [1:0]       out7_drive_strength,
    output logic             second_feedback_integer_mode
);

    localparam int NUM_PINS = 9;
    localparam int PIN_CRYSTAL_OSCILLATOR = 0;
    localparam int PIN_EXT  = 1;
    localparam int PIN_PLL1 = 2;
    localparam int PIN_PLL2 = 3;
    localparam int PIN_OEB  = 4;
    localparam int PIN_OUT0 = 5;
    localparam int ADDR_LSB_P = clock_output_pkg::ADDR_LSB;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------

    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_meta_reg;
    logic [NUM_PINS-1:0] pin_sync_reg;

    assign pin_raw = {out_source, output_enable_low_pin, second_pll, first_pll,
                      external_clock_input, crystal_oscillator};

    // Every pin input is asynchronous to pclk, so the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
        end
    end

    // Second synchroniser stage; the only stage that logic may read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_reg <= '0;
        end else begin
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // APB slave.
    // ------------------------------------------------------------------

    logic [7:0] out7_control_reg;
    logic [7:0] disable_state_reg;
    logic [7:0] output_enable_reg;
    logic [7:0] status_value;
    logic [7:0] reg_index;
    logic       addr_aligned;
    logic       addr_mapped;
    logic       access_done;
    logic       write_strobe;
    logic [7:0] read_value;

    assign reg_index    = paddr[ADDR_LSB_P+7:ADDR_LSB_P];
    assign addr_aligned = (paddr[ADDR_LSB_P-1:0] == '0)
                       && (paddr[31:ADDR_LSB_P+8] == '0);
    assign addr_mapped  = addr_aligned
                       && ((reg_index == clock_output_pkg::IDX_STATUS)
                        || (reg_index == clock_output_pkg::IDX_OUTPUT_ENABLE)
                        || (reg_index == clock_output_pkg::IDX_OUT7_CONTROL)
                        || (reg_index == clock_output_pkg::IDX_DISABLE_STATE));

    // The access completes at the edge where pready is high with psel and penable.
    assign access_done  = psel && penable && pready;
    assign write_strobe = access_done && pwrite && addr_mapped;

    // One wait state: pready rises in the second access cycle, then drops again.
    // Registering it keeps pready a clean flop output at the cost of one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Read mux; bits above the eight-bit register read as zero.
    always_comb begin
        read_value = 8'h00;
        if (reg_index == clock_output_pkg::IDX_STATUS) begin
            read_value = status_value;
        end else if (reg_index == clock_output_pkg::IDX_OUTPUT_ENABLE) begin
            read_value = output_enable_reg;
        end else if (reg_index == clock_output_pkg::IDX_OUT7_CONTROL) begin
            read_value = out7_control_reg;
        end else if (reg_index == clock_output_pkg::IDX_DISABLE_STATE) begin
            read_value = disable_state_reg;
        end
    end

    // Read data and error are loaded together with pready so they are valid with it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= (addr_mapped && !pwrite) ? {24'h00_0000, read_value}
                                                : 32'h0000_0000;
            pslverr <= !addr_mapped;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Output seven control; the status register is read only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out7_control_reg <= clock_output_pkg::RST_OUT7_CONTROL;
        end else if (write_strobe && reg_index == clock_output_pkg::IDX_OUT7_CONTROL) begin
            out7_control_reg <= pwdata[7:0];
        end
    end

    // Two bits per output 0 to 3, all zero after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disable_state_reg <= clock_output_pkg::RST_DISABLE_STATE;
        end else if (write_strobe && reg_index == clock_output_pkg::IDX_DISABLE_STATE) begin
            disable_state_reg <= pwdata[7:0];
        end
    end

    // A one in bit n disables output n; bits 7:4 are stored for outputs outside this block.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_enable_reg <= clock_output_pkg::RST_OUTPUT_ENABLE;
        end else if (write_strobe && reg_index == clock_output_pkg::IDX_OUTPUT_ENABLE) begin
            output_enable_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Output seven path.
    // ------------------------------------------------------------------

    logic       out7_power_down;
    logic       out7_divider_pll_select;
    logic       out7_invert;
    logic [1:0] out7_source_select;
    logic       divider_ref;
    logic       divider_ref_prev_reg;
    logic       divider_out_reg;
    logic       out7_selected;
    logic       out7_live;

    assign out7_power_down         = out7_control_reg[clock_output_pkg::POS_POWER_DOWN];
    assign out7_divider_pll_select = out7_control_reg[clock_output_pkg::POS_PLL_SELECT];
    assign out7_invert             = out7_control_reg[clock_output_pkg::POS_INVERT];
    assign out7_source_select      = out7_control_reg[clock_output_pkg::POS_SOURCE_HI:
                                                      clock_output_pkg::POS_SOURCE_LO];

    // Reference of the divider: first PLL on 0, second PLL on 1.
    assign divider_ref = out7_divider_pll_select ? pin_sync_reg[PIN_PLL2]
                                                 : pin_sync_reg[PIN_PLL1];

    // Remember the previous reference level to find its rising edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_ref_prev_reg <= 1'b0;
        end else begin
            divider_ref_prev_reg <= divider_ref;
        end
    end

    // The divider stage is a fixed divide-by-two of its reference; its ratio
    // registers live outside this block, so only the stage's existence is modelled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_out_reg <= 1'b0;
        end else if (divider_ref && !divider_ref_prev_reg) begin
            divider_out_reg <= !divider_out_reg;
        end
    end

    // Source selection; the reserved code selects a constant low, which the invert bit still applies to.
    always_comb begin
        case (out7_source_select)
            clock_output_pkg::SRC_CRYSTAL:  out7_selected = pin_sync_reg[PIN_CRYSTAL_OSCILLATOR];
            clock_output_pkg::SRC_EXTERNAL: out7_selected = pin_sync_reg[PIN_EXT];
            clock_output_pkg::SRC_DIVIDER:  out7_selected = divider_out_reg;
            default:                        out7_selected = 1'b0;
        endcase
    end

    assign out7_live = !out7_power_down;

    // Output seven pin: inverted on request, driver off and low while powered down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_seven    <= 1'b0;
            output_seven_oe <= 1'b0;
        end else if (out7_power_down) begin
            output_seven    <= 1'b0;
            output_seven_oe <= 1'b0;
        end else begin
            output_seven    <= out7_selected ^ out7_invert;
            output_seven_oe <= 1'b1;
        end
    end

    // Drive strength code goes to the pad: 00/01/10/11 = 2/4/6/8 mA.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out7_drive_strength <= 2'h0;
        end else begin
            out7_drive_strength <= out7_control_reg[clock_output_pkg::POS_DRIVE_HI:
                                                    clock_output_pkg::POS_DRIVE_LO];
        end
    end

    // The integer-mode bit is only stored and handed on; software owns its value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_feedback_integer_mode <= 1'b0;
        end else begin
            second_feedback_integer_mode <=
                out7_control_reg[clock_output_pkg::POS_FB_INT_MODE];
        end
    end

    // ------------------------------------------------------------------
    // Outputs 0 to 3 and their disabled behaviour.
    // ------------------------------------------------------------------

    logic       pin_disable;
    logic [3:0] disable_request;
    logic [3:0] stage_disabled;

    // The pin is active low: a high level asks every output to disable.
    assign pin_disable     = pin_sync_reg[PIN_OEB];
    assign disable_request = output_enable_reg[3:0] | {4{pin_disable}};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            // Field of output n sits at bits 2n+1:2n.
            output_disable_stage u_stage (
                .pclk                  (pclk),
                .presetn               (presetn),
                .source_clk            (pin_sync_reg[PIN_OUT0+gi]),
                .output_disabled_level (disable_state_reg[gi*2 +: 2]),
                .disable_request       (disable_request[gi]),
                .pin_out               (out_pin[gi]),
                .pin_oe                (out_pin_oe[gi]),
                .is_disabled           (stage_disabled[gi])
            );
        end
    endgenerate

    // Status: pin level, outputs actually parked, and output seven driver state.
    always_comb begin
        status_value = 8'h00;
        status_value[clock_output_pkg::POS_STAT_PIN_LEVEL] = pin_disable;
        status_value[clock_output_pkg::POS_STAT_DISABLED +: 4] = stage_disabled;
        status_value[clock_output_pkg::POS_STAT_OUT7_LIVE] = out7_live;
    end

endmodule : clock_output_control

`default_nettype wire

// ==== clock_output_control_monitor.sv ====
`default_nettype none

// Watches the ports of the output stage and ties its outputs to the written configuration.
module clock_output_control_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        crystal_oscillator,
    input wire logic        external_clock_input,
    input wire logic        first_pll,
    input wire logic        second_pll,
    input wire logic [3:0]  out_source,
    input wire logic        output_enable_low_pin,
    input wire logic [3:0]  out_pin,
    input wire logic [3:0]  out_pin_oe,
    input wire logic        output_seven,
    input wire logic        output_seven_oe,
    input wire logic [1:0]  out7_drive_strength,
    input wire logic        second_feedback_integer_mode
);
    localparam logic [31:0] A_CTL = {22'h0, clock_output_pkg::IDX_OUT7_CONTROL, 2'h0};
    localparam logic [31:0] A_DIS = {22'h0, clock_output_pkg::IDX_DISABLE_STATE, 2'h0};
    localparam logic [31:0] A_EN  = {22'h0, clock_output_pkg::IDX_OUTPUT_ENABLE, 2'h0};
    logic [7:0] ctl_reg;
    logic [7:0] dis_reg;
    logic [7:0] en_reg;
    logic [1:0] age_reg;
    logic       wr_done;
    logic       live;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadows follow completed writes, so outputs can be compared with what software set.
    assign wr_done = psel && penable && pready && pwrite && !pslverr;
    assign live    = (age_reg == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= 8'h00;
            dis_reg <= 8'h00;
            en_reg  <= 8'h00;
        end else if (wr_done) begin
            if (paddr == A_CTL) ctl_reg <= pwdata[7:0];
            if (paddr == A_DIS) dis_reg <= pwdata[7:0];
            if (paddr == A_EN) en_reg <= pwdata[7:0];
        end
    end

    // Pin checks wait three edges after reset, since the synchronisers start from zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_reg <= 2'h0;
        else if (!live) age_reg <= age_reg + 2'h1;
    end

    // Expected {enable, level} of one parked or passing output.
    function automatic logic [1:0] park(input logic [1:0] f, input logic d, input logic s);
        if (f == clock_output_pkg::DIS_NEVER || !d) return {1'b1, s};
        if (f == clock_output_pkg::DIS_HIZ) return 2'h0;
        return {1'b1, f[0]};
    endfunction : park

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    bad_addr_a: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access answered without error");
    read_back_a: assert property (
        pready && !pwrite && paddr == A_DIS |-> prdata == {24'h0, dis_reg})
        else $error("disable state read differs from written value");
    power_down_a: assert property (live |-> output_seven_oe == !$past(ctl_reg[7])
        && (!$past(ctl_reg[7]) || !output_seven))
        else $error("output seven power state wrong");
    crystal_path_a: assert property (
        live && $past(ctl_reg[3:2]) == 2'h0 && !$past(ctl_reg[7])
        |-> output_seven == ($past(crystal_oscillator, 3) ^ $past(ctl_reg[4])))
        else $error("crystal path to output seven wrong");
    external_path_a: assert property (
        live && $past(ctl_reg[3:2]) == 2'h1 && !$past(ctl_reg[7])
        |-> output_seven == ($past(external_clock_input, 3) ^ $past(ctl_reg[4])))
        else $error("external path to output seven wrong");
    drive_copy_a: assert property (live |-> out7_drive_strength == $past(ctl_reg[1:0]))
        else $error("drive strength does not follow control");
    for (genvar g = 0; g < 4; g++) begin : gen_park
        park_level_a: assert property (
            live |-> {out_pin_oe[g], out_pin[g]} == park($past(dis_reg[2*g +: 2]),
            $past(en_reg[g]) || $past(output_enable_low_pin, 3), $past(out_source[g], 3)))
            else $error("parked output level wrong");
    end

    cover property (live && !output_seven_oe);
    cover property (live && $past(ctl_reg[3:2]) == 2'h3);
    cover property (out_pin_oe != 4'hF && live);
    cover property (pready && pslverr);
endmodule : clock_output_control_monitor

bind clock_output_control clock_output_control_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .crystal_oscillator(crystal_oscillator), .external_clock_input(external_clock_input),
    .first_pll(first_pll), .second_pll(second_pll), .out_source(out_source),
    .output_enable_low_pin(output_enable_low_pin), .out_pin(out_pin), .out_pin_oe(out_pin_oe),
    .output_seven(output_seven), .output_seven_oe(output_seven_oe),
    .out7_drive_strength(out7_drive_strength),
    .second_feedback_integer_mode(second_feedback_integer_mode)
);

`default_nettype wire

// ==== clock_output_control_tb_top.sv ====
`default_nettype none

module clock_output_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        crystal_oscillator, external_clock_input, first_pll, second_pll;
    logic [3:0]  out_source, out_pin, out_pin_oe;
    logic        output_enable_low_pin, output_seven, output_seven_oe, err;
    logic [1:0]  out7_drive_strength;
    logic        second_feedback_integer_mode;
    logic [5:0]  h0, h1, h2;
    logic [7:0]  v, dis, en;
    int          seed = 72104;
    int          cyc, n, e, n_mismatch, comparisons;

    clock_output_control DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .crystal_oscillator(crystal_oscillator), .external_clock_input(external_clock_input),
        .first_pll(first_pll), .second_pll(second_pll), .out_source(out_source),
        .output_enable_low_pin(output_enable_low_pin), .out_pin(out_pin),
        .out_pin_oe(out_pin_oe), .output_seven(output_seven), .output_seven_oe(output_seven_oe),
        .out7_drive_strength(out7_drive_strength),
        .second_feedback_integer_mode(second_feedback_integer_mode)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Source clocks: PLLs at periods of 8 and 12 cycles so the selection shows in the rate.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        crystal_oscillator <= cyc[1];
        first_pll <= (cyc % 8) < 4;
        second_pll <= (cyc % 12) < 6;
        external_clock_input <= 1'($random(seed));
        out_source <= 4'($random(seed));
    end

    // Pin history; the output register shows pins from three edges back.
    always @(posedge pclk) begin
        h0 <= {external_clock_input, crystal_oscillator, out_source};
        h1 <= h0;
        h2 <= h1;
    end

    function automatic logic [31:0] a(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction : a

    function automatic logic [1:0] park_exp(input logic [1:0] f, input logic d, input logic s);
        if (f == 2'h3 || !d) return {1'b1, s};
        return (f == 2'h2) ? 2'h0 : {1'b1, f[0]};
    endfunction : park_exp

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; waiting an edge first keeps back-to-back calls from re-driving psel.
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end

    // Main sequence: reset values, refusals, output seven paths, then parking of outputs 0..3.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, output_enable_low_pin} = '0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, a(clock_output_pkg::IDX_DISABLE_STATE), 32'h0);
        check(rd, 32'h0);
        apb(1'b0, a(clock_output_pkg::IDX_STATUS), 32'h0);
        check(rd, 32'h1 << clock_output_pkg::POS_STAT_OUT7_LIVE);
        apb(1'b0, 32'h80, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        apb(1'b1, a(clock_output_pkg::IDX_OUT7_CONTROL) | 32'h1, 32'hFF);
        check(32'(err), 32'h1);
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            apb(1'b1, a(clock_output_pkg::IDX_DISABLE_STATE), {24'($random(seed)), v});
            apb(1'b0, a(clock_output_pkg::IDX_DISABLE_STATE), 32'h0);
            check(rd, {24'h0, v});
        end
        for (int i = 0; i < 8; i++) begin
            v = {1'b0, 2'($random(seed)), i[2], 1'b0, i[0], i[1:0]};
            apb(1'b1, a(clock_output_pkg::IDX_OUT7_CONTROL), {24'h0, v});
            repeat (5) @(posedge pclk);
            @(negedge pclk);
            check(32'(out7_drive_strength), 32'(i[1:0]));
            check(32'(second_feedback_integer_mode), 32'(v[6]));
            for (int c = 0; c < 6; c++) begin
                check(32'(output_seven), 32'((i[0] ? h2[5] : h2[4]) ^ i[2]));
                @(negedge pclk);
            end
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, a(clock_output_pkg::IDX_OUT7_CONTROL), i ? 32'h90 : 32'h80);
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            check(32'({output_seven_oe, output_seven}), 32'h0);
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, a(clock_output_pkg::IDX_OUT7_CONTROL), s ? 32'h2C : 32'h0C);
            repeat (8) @(posedge pclk);
            n = 0;
            for (int c = 0; c < 96; c++) begin
                @(negedge pclk);
                v[0] = output_seven;
                @(posedge pclk);
                #1 n += (output_seven !== v[0]);
            end
            e = 96 / (s ? 12 : 8);
            check(32'(n >= e - 1 && n <= e + 1), 32'h1);
            check(32'(output_seven_oe), 32'h1);
        end
        for (int k = 0; k < 14; k++) begin
            dis = (k < 8) ? {4{k[1:0]}} : (k == 8) ? 8'hE4 : 8'($random(seed));
            en = (k < 8 && k[2]) ? 8'h00 : 8'($random(seed));
            apb(1'b1, a(clock_output_pkg::IDX_DISABLE_STATE), {24'h0, dis});
            apb(1'b1, a(clock_output_pkg::IDX_OUTPUT_ENABLE), {24'h0, en});
            output_enable_low_pin <= (k < 8) ? k[2] : 1'($random(seed));
            repeat (5) @(posedge pclk);
            @(negedge pclk);
            for (int m = 0; m < 4; m++) begin
                check(32'({out_pin_oe[m], out_pin[m]}),
                    32'(park_exp(dis[2*m +: 2], en[m] | output_enable_low_pin, h2[m])));
            end
        end
        summarize();
    end
endmodule : clock_output_control_tb_top

`default_nettype wire

// ==== clock_output_pkg.sv ====
// What this block does
// - Power-down bit 7 turns output seven driver off.
// - Bit 5 picks first or second PLL for divider.
// - Invert bit 4 inverts output seven clock.
// - Source code zero routes crystal straight to output.
// - Source code one buffers external clock input out.
// - Source code three feeds output from divider.
// - Drive field codes select 2, 4, 6, 8 mA.
// - Disable-state register holds two bits per output.
// - Disabled output driven low on 00, high 01.
// - Field 10 puts disabled output in high impedance.
// - Field 11 keeps output running, ignores all disables.
// - Enable register or pin deassertion disables an output.
// - Disable-state register resets to all zeros.
`default_nettype none

package clock_output_pkg;

    // Register indices; byte address on the bus is four times the index.
    localparam logic [7:0] IDX_STATUS        = 8'h00;
    localparam logic [7:0] IDX_OUTPUT_ENABLE = 8'h03;
    localparam logic [7:0] IDX_OUT7_CONTROL  = 8'h17;
    localparam logic [7:0] IDX_DISABLE_STATE = 8'h18;
    localparam int         ADDR_LSB          = 2;

    // Field positions of the output seven control register.
    localparam int POS_POWER_DOWN  = 7;
    localparam int POS_FB_INT_MODE = 6;
    localparam int POS_PLL_SELECT  = 5;
    localparam int POS_INVERT      = 4;
    localparam int POS_SOURCE_HI   = 3;
    localparam int POS_SOURCE_LO   = 2;
    localparam int POS_DRIVE_HI    = 1;
    localparam int POS_DRIVE_LO    = 0;

    // Source selection codes.
    localparam logic [1:0] SRC_CRYSTAL  = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL = 2'h1;
    localparam logic [1:0] SRC_RESERVED = 2'h2;
    localparam logic [1:0] SRC_DIVIDER  = 2'h3;

    // Disabled-level codes, one two-bit field per output.
    localparam logic [1:0] DIS_LOW   = 2'h0;
    localparam logic [1:0] DIS_HIGH  = 2'h1;
    localparam logic [1:0] DIS_HIZ   = 2'h2;
    localparam logic [1:0] DIS_NEVER = 2'h3;
    localparam int         DIS_FIELD_WIDTH = 2;

    // Reset values.
    localparam logic [7:0] RST_OUT7_CONTROL  = 8'h00;
    localparam logic [7:0] RST_DISABLE_STATE = 8'h00;
    localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;

    // Status register layout.
    localparam int POS_STAT_PIN_LEVEL = 0;
    localparam int POS_STAT_DISABLED  = 1;
    localparam int POS_STAT_OUT7_LIVE = 5;

    // Synchroniser depth for every pin input.
    localparam int SYNC_STAGES = 2;

endpackage : clock_output_pkg

`default_nettype wire

// ==== output_disable_stage.sv ====
`default_nettype none

// One output of the group 0 to 3: passes its clock or parks it as its field says.
module output_disable_stage (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       source_clk,
    input  wire logic [1:0] output_disabled_level,
    input  wire logic       disable_request,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            is_disabled
);

    logic parked;

    // Field 11 overrides every disable request, from register or pin.
    assign parked = disable_request
                  && (output_disabled_level != clock_output_pkg::DIS_NEVER);

    // The pin level and enable are registered so the pads never see a glitch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out     <= 1'b0;
            pin_oe      <= 1'b0;
            is_disabled <= 1'b0;
        end else begin
            is_disabled <= parked;
            if (!parked) begin
                pin_out <= source_clk;
                pin_oe  <= 1'b1;
            end else begin
                case (output_disabled_level)
                    clock_output_pkg::DIS_LOW: begin
                        pin_out <= 1'b0;
                        pin_oe  <= 1'b1;
                    end
                    clock_output_pkg::DIS_HIGH: begin
                        pin_out <= 1'b1;
                        pin_oe  <= 1'b1;
                    end
                    clock_output_pkg::DIS_HIZ: begin
                        pin_out <= 1'b0;
                        pin_oe  <= 1'b0;
                    end
                    default: begin
                        pin_out <= source_clk;
                        pin_oe  <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : output_disable_stage

`default_nettype wire
